// ===== hdl/perf_interval_regs.sv
// current quarter-hour, history queue and daily register logic
`timescale 1ns/100ps

// Functional notes
// - doubt flag set when elapsed seconds differ from 900 by over 10.
// - clock preset beyond 10 s or lost data mark interval doubtful; init marks only history entries doubtful.
// - elapsed-second counter reaches at least 900.
// - elapsed-second counter saturates until reset or transfer.
// - period end copies current into history, then clears current.
// - clock set outside interval acts as a full period end.
// - period start zeroes count and seconds, clears doubt, loads stamp.
// - current register contents always visible on report ports.
// - start of processing clears current seconds, doubt and count.
// - history of 16 shifts one older per period end, newest in entry one.
// - each history entry carries its quarter-hour end stamp.
// - clock preset leaves stored history stamps untouched.
// - any history entry readable on request.
// - start fills history with zero stamp, zero seconds, doubt true, zero count.
// - daily register accumulates each performance value.
// - daily register maximum exceeds a full interval's nominal count.
// - daily register saturates until reset or transferred.
// - daily register may be updated in batches.
module perf_interval_regs
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // per-second input and ticks from the wall clock logic
  input wire logic monitor_second_tick_in,
  input wire logic [perf_interval_pkg::VALUE_W-1:0] per_second_perf_value_in,
  input wire logic quarter_hour_tick_in,
  input wire logic day_boundary_tick_in,
  input wire logic [perf_interval_pkg::STAMP_W-1:0] wall_stamp_in,
  // events from management and equipment
  input wire logic start_processing_in,
  input wire logic clock_preset_far_in,
  input wire logic clock_preset_out_of_interval_in,
  input wire logic data_lost_in,
  // report requests
  input wire logic report_req_in,
  input wire logic [perf_interval_pkg::HIST_IDX_W-1:0] report_index_in,
  // current quarter-hour report
  output logic report_valid_out,
  output logic [perf_interval_pkg::COUNT_W-1:0] cur_count_out,
  output logic [perf_interval_pkg::SECS_W-1:0] cur_seconds_out,
  output logic cur_doubt_out,
  output logic [perf_interval_pkg::STAMP_W-1:0] cur_stamp_out,
  // history report
  output logic [perf_interval_pkg::COUNT_W-1:0] hist_count_out,
  output logic [perf_interval_pkg::SECS_W-1:0] hist_seconds_out,
  output logic hist_doubt_out,
  output logic [perf_interval_pkg::STAMP_W-1:0] hist_stamp_out,
  // daily register
  output logic [perf_interval_pkg::DAILY_W-1:0] daily_running_count_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [perf_interval_pkg::COUNT_W-1:0] cur_count_q;
  logic [perf_interval_pkg::SECS_W-1:0] cur_secs_q;
  logic cur_doubt_q;
  logic [perf_interval_pkg::STAMP_W-1:0] cur_stamp_q;
  logic [perf_interval_pkg::COUNT_W-1:0] hist_count_q [perf_interval_pkg::HISTORY_DEPTH];
  logic [perf_interval_pkg::SECS_W-1:0] hist_secs_q [perf_interval_pkg::HISTORY_DEPTH];
  logic hist_doubt_q [perf_interval_pkg::HISTORY_DEPTH];
  logic [perf_interval_pkg::STAMP_W-1:0] hist_stamp_q [perf_interval_pkg::HISTORY_DEPTH];
  logic [perf_interval_pkg::DAILY_W-1:0] daily_q;
  logic [perf_interval_pkg::COUNT_W-1:0] batch_q;
  logic period_end;
  logic secs_off;
  logic [perf_interval_pkg::COUNT_W:0] count_sum;
  logic [perf_interval_pkg::DAILY_W:0] daily_sum;

  // ----------------------------------------------------------------
  // period end decode
  // ----------------------------------------------------------------
  // a preset outside the interval is handled exactly like the tick
  assign period_end = quarter_hour_tick_in | clock_preset_out_of_interval_in;
  // elapsed time outside 890..910 seconds makes the interval doubtful
  assign secs_off = (cur_secs_q < perf_interval_pkg::SECS_LOW_OK) ||
                    (cur_secs_q > perf_interval_pkg::SECS_HIGH_OK);
  assign count_sum = {1'b0, cur_count_q} + {{(perf_interval_pkg::COUNT_W
                     - perf_interval_pkg::VALUE_W + 1){1'b0}}, per_second_perf_value_in};

  // ----------------------------------------------------------------
  // current quarter-hour register
  // ----------------------------------------------------------------
  // start of processing outranks a period end: both clear the register
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cur_count_q <= '0;
      cur_secs_q <= '0;
      cur_doubt_q <= 1'b0;
      cur_stamp_q <= perf_interval_pkg::STAMP_ZERO;
    end
    else if (start_processing_in)
    begin
      cur_count_q <= '0;
      cur_secs_q <= '0;
      cur_doubt_q <= 1'b0;
      cur_stamp_q <= wall_stamp_in;
    end
    else if (period_end)
    begin
      cur_count_q <= '0;
      cur_secs_q <= '0;
      cur_doubt_q <= 1'b0;
      cur_stamp_q <= wall_stamp_in;
    end
    else
    begin
      if (monitor_second_tick_in)
      begin
        // count saturates rather than wrapping to a misleading small value
        cur_count_q <= count_sum[perf_interval_pkg::COUNT_W] ? perf_interval_pkg::COUNT_MAX
                       : count_sum[perf_interval_pkg::COUNT_W-1:0];
        if (cur_secs_q != perf_interval_pkg::SECS_MAX)
          cur_secs_q <= cur_secs_q + 10'h001;
      end
      if (clock_preset_far_in || data_lost_in)
        cur_doubt_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // history queue
  // ----------------------------------------------------------------
  // stamps only move with their entry, so a preset never rewrites them
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < perf_interval_pkg::HISTORY_DEPTH; i++)
      begin
        hist_count_q[i] <= '0;
        hist_secs_q[i] <= '0;
        hist_doubt_q[i] <= 1'b1;
        hist_stamp_q[i] <= perf_interval_pkg::STAMP_ZERO;
      end
    end
    else if (start_processing_in)
    begin
      for (int i = 0; i < perf_interval_pkg::HISTORY_DEPTH; i++)
      begin
        hist_count_q[i] <= '0;
        hist_secs_q[i] <= '0;
        hist_doubt_q[i] <= 1'b1;
        hist_stamp_q[i] <= perf_interval_pkg::STAMP_ZERO;
      end
    end
    else if (period_end)
    begin
      for (int i = perf_interval_pkg::HISTORY_DEPTH - 1; i > 0; i--)
      begin
        hist_count_q[i] <= hist_count_q[i-1];
        hist_secs_q[i] <= hist_secs_q[i-1];
        hist_doubt_q[i] <= hist_doubt_q[i-1];
        hist_stamp_q[i] <= hist_stamp_q[i-1];
      end
      hist_count_q[0] <= cur_count_q;
      hist_secs_q[0] <= cur_secs_q;
      hist_doubt_q[0] <= cur_doubt_q | secs_off | clock_preset_far_in | data_lost_in;
      hist_stamp_q[0] <= wall_stamp_in;
    end
  end

  // ----------------------------------------------------------------
  // daily register, updated once per quarter hour
  // ----------------------------------------------------------------
  // batching keeps the wide adder off the per-second path
  assign daily_sum = {1'b0, daily_q} + {{(perf_interval_pkg::DAILY_W
                     - perf_interval_pkg::COUNT_W + 1){1'b0}}, batch_q};

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      batch_q <= '0;
    else if (start_processing_in || day_boundary_tick_in)
      batch_q <= '0;
    else if (period_end)
      batch_q <= cur_count_q;
    else
      batch_q <= '0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      daily_q <= '0;
    else if (start_processing_in || day_boundary_tick_in)
      daily_q <= '0;
    else if (daily_sum[perf_interval_pkg::DAILY_W])
      daily_q <= perf_interval_pkg::DAILY_MAX;
    else
      daily_q <= daily_sum[perf_interval_pkg::DAILY_W-1:0];
  end

  // ----------------------------------------------------------------
  // report outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      report_valid_out <= 1'b0;
      cur_count_out <= '0;
      cur_seconds_out <= '0;
      cur_doubt_out <= 1'b0;
      cur_stamp_out <= perf_interval_pkg::STAMP_ZERO;
      hist_count_out <= '0;
      hist_seconds_out <= '0;
      hist_doubt_out <= 1'b0;
      hist_stamp_out <= perf_interval_pkg::STAMP_ZERO;
      daily_running_count_out <= '0;
    end
    else
    begin
      report_valid_out <= report_req_in;
      cur_count_out <= cur_count_q;
      cur_seconds_out <= cur_secs_q;
      cur_doubt_out <= cur_doubt_q | secs_off;
      cur_stamp_out <= cur_stamp_q;
      if (report_req_in)
      begin
        hist_count_out <= hist_count_q[report_index_in];
        hist_seconds_out <= hist_secs_q[report_index_in];
        hist_doubt_out <= hist_doubt_q[report_index_in];
        hist_stamp_out <= hist_stamp_q[report_index_in];
      end
      daily_running_count_out <= daily_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_secs_step;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (monitor_second_tick_in && !period_end && !start_processing_in
     && cur_secs_q < perf_interval_pkg::SECS_MAX) |=> cur_secs_q == $past(cur_secs_q) + 10'h001;
  endproperty
  a_secs_step: assert property (p_secs_step) else $error("seconds did not step");

  property p_secs_hold;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (cur_secs_q == perf_interval_pkg::SECS_MAX && !period_end && !start_processing_in)
      |=> cur_secs_q == perf_interval_pkg::SECS_MAX;
  endproperty
  a_secs_hold: assert property (p_secs_hold) else $error("seconds wrapped");

  property p_period_clear;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    period_end |=> (cur_count_q == '0 && cur_secs_q == '0 && !cur_doubt_q);
  endproperty
  a_period_clear: assert property (p_period_clear) else $error("period start not clean");

  property p_shift;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (period_end && !start_processing_in) |=> (hist_count_q[0] == $past(cur_count_q)
      && hist_stamp_q[1] == $past(hist_stamp_q[0]));
  endproperty
  a_shift: assert property (p_shift) else $error("history did not shift");

  property p_start_hist;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    start_processing_in |=> (hist_doubt_q[15] && hist_stamp_q[15] == '0 && hist_count_q[0] == '0);
  endproperty
  a_start_hist: assert property (p_start_hist) else $error("history init wrong");

  property p_start_cur;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    start_processing_in |=> (cur_secs_q == '0 && !cur_doubt_q && cur_count_q == '0);
  endproperty
  a_start_cur: assert property (p_start_cur) else $error("current init wrong");

  property p_doubt_set;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    ((data_lost_in || clock_preset_far_in) && !period_end && !start_processing_in) |=> cur_doubt_q;
  endproperty
  a_doubt_set: assert property (p_doubt_set) else $error("doubt not set");

  property p_daily_sat;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (daily_q == perf_interval_pkg::DAILY_MAX && !day_boundary_tick_in && !start_processing_in)
      |=> daily_q == perf_interval_pkg::DAILY_MAX;
  endproperty
  a_daily_sat: assert property (p_daily_sat) else $error("daily wrapped");

  property p_report;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    report_req_in |=> (report_valid_out && cur_count_out == $past(cur_count_q));
  endproperty
  a_report: assert property (p_report) else $error("report stale");

endmodule : perf_interval_regs

// ===== include/perf_interval_pkg.sv
// shared constants for the interval performance register block
package perf_interval_pkg;
  // ----------------------------------------------------------------
  // interval geometry
  // ----------------------------------------------------------------
  localparam int unsigned NOMINAL_SECONDS = 900;
  localparam int unsigned DOUBT_MARGIN_S = 10;
  localparam int unsigned HISTORY_DEPTH = 16;
  localparam int unsigned HIST_IDX_W = 4;
  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int unsigned SECS_W = 10;
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned VALUE_W = 16;
  localparam int unsigned DAILY_W = 32;
  localparam int unsigned STAMP_W = 32;
  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic [SECS_W-1:0] SECS_MAX = 10'h3ff;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 24'hffffff;
  localparam logic [DAILY_W-1:0] DAILY_MAX = 32'hffffffff;
  localparam logic [SECS_W-1:0] SECS_LOW_OK = 10'h37a;
  localparam logic [SECS_W-1:0] SECS_HIGH_OK = 10'h38e;
  localparam logic [STAMP_W-1:0] STAMP_ZERO = 32'h00000000;
endpackage : perf_interval_pkg

// ===== verif/perf_feed_model.sv
// per-second performance source model feeding the interval registers
`timescale 1ns/100ps
module perf_feed_model
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // control from the bench
  input wire logic run_in,
  input wire logic [perf_interval_pkg::VALUE_W-1:0] value_in,
  // feed towards the block
  output logic tick_out,
  output logic [perf_interval_pkg::VALUE_W-1:0] value_out
);
  // ----------------------------------------------------------------
  // second ticks, compressed to one every second cycle
  // ----------------------------------------------------------------
  // off-tick value is inverted so stale data never looks valid
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tick_out <= 1'b0;
      value_out <= 16'h0000;
    end
    else
    begin
      tick_out <= run_in && !tick_out;
      value_out <= (run_in && !tick_out) ? value_in : ~value_out;
    end
  end
endmodule : perf_feed_model

// ===== verif/tb_perf_interval_regs.sv
// self-checking bench for the interval performance register block
`timescale 1ns/100ps
module tb_perf_interval_regs;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic feed_run = 1'b0;
  logic [15:0] feed_value = 16'h0000;
  logic sec_tick;
  logic [15:0] sec_value;
  logic [5:0] ev = 6'h00;
  logic [31:0] stamp = 32'h00000000;
  logic report_req = 1'b0;
  logic [3:0] report_index = 4'h0;
  logic report_valid_out, cur_doubt_out, hist_doubt_out;
  logic [23:0] cur_count_out, hist_count_out;
  logic [9:0] cur_seconds_out, hist_seconds_out;
  logic [31:0] cur_stamp_out, hist_stamp_out, daily_running_count_out;
  int fails = 0;
  int checked = 0;
  // 200 MHz
  always #2.5 clk_sys_in = ~clk_sys_in;
  perf_feed_model u_feed (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .run_in(feed_run),
    .value_in(feed_value), .tick_out(sec_tick), .value_out(sec_value));
  perf_interval_regs u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .monitor_second_tick_in(sec_tick), .per_second_perf_value_in(sec_value),
    .quarter_hour_tick_in(ev[1]), .day_boundary_tick_in(ev[2]), .wall_stamp_in(stamp),
    .start_processing_in(ev[0]), .clock_preset_far_in(ev[3]),
    .clock_preset_out_of_interval_in(ev[4]), .data_lost_in(ev[5]),
    .report_req_in(report_req), .report_index_in(report_index),
    .report_valid_out(report_valid_out), .cur_count_out(cur_count_out),
    .cur_seconds_out(cur_seconds_out), .cur_doubt_out(cur_doubt_out),
    .cur_stamp_out(cur_stamp_out), .hist_count_out(hist_count_out),
    .hist_seconds_out(hist_seconds_out), .hist_doubt_out(hist_doubt_out),
    .hist_stamp_out(hist_stamp_out), .daily_running_count_out(daily_running_count_out));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle event pulse, then let the block settle
  task automatic pulse(input int k);
    @(posedge clk_sys_in);
    ev[k] <= 1'b1;
    @(posedge clk_sys_in);
    ev[k] <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : pulse
  // counts ticks at the edges the block samples them
  task automatic run_secs(input int n, input logic [15:0] v);
    @(posedge clk_sys_in);
    feed_run <= 1'b1;
    feed_value <= v;
    repeat (n)
    begin
      @(posedge clk_sys_in);
      while (sec_tick !== 1'b1) @(posedge clk_sys_in);
    end
    feed_run <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : run_secs
  task automatic read_hist(input logic [3:0] idx, input logic [31:0] c, input logic [31:0] s,
                           input logic [31:0] d, input logic [31:0] st);
    @(posedge clk_sys_in);
    report_req <= 1'b1;
    report_index <= idx;
    @(posedge clk_sys_in);
    report_req <= 1'b0;
    #1;
    chk(report_valid_out, 32'h1);
    chk(hist_count_out, c);
    chk(hist_seconds_out, s);
    chk(hist_doubt_out, d);
    chk(hist_stamp_out, st);
  endtask : read_hist
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // watchdog sized well above the roughly 7600 cycles the tests need
  initial
  begin
    #200000;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    pulse(0);
    chk(cur_count_out, 32'h0);
    chk(cur_seconds_out, 32'h0);
    for (int i = 0; i < perf_interval_pkg::HISTORY_DEPTH; i++)
      read_hist(4'(i), 32'h0, 32'h0, 32'h1, 32'h0);
    $display("test 1 done");
    stamp <= 32'h00000111;
    run_secs(5, 16'h0003);
    chk(cur_count_out, 32'hf);
    chk(cur_seconds_out, 32'h5);
    chk(cur_doubt_out, 32'h1);
    pulse(1);
    chk(cur_count_out, 32'h0);
    chk(cur_seconds_out, 32'h0);
    chk(cur_stamp_out, 32'h00000111);
    read_hist(4'h0, 32'hf, 32'h5, 32'h1, 32'h00000111);
    read_hist(4'h1, 32'h0, 32'h0, 32'h1, 32'h0);
    $display("test 2 done");
    stamp <= 32'h00000222;
    run_secs(900, 16'h0001);
    chk(cur_doubt_out, 32'h0);
    pulse(1);
    read_hist(4'h0, 32'h384, 32'h384, 32'h0, 32'h00000222);
    read_hist(4'h1, 32'hf, 32'h5, 32'h1, 32'h00000111);
    chk(daily_running_count_out, 32'h393);
    $display("test 3 done");
    // a far clock preset, then lost data, each in a full-length period
    for (int k = 3; k <= 5; k += 2)
    begin
      stamp <= 32'h00000330 + 32'(k);
      run_secs(450, 16'h0001);
      pulse(k);
      run_secs(450, 16'h0001);
      pulse(1);
      read_hist(4'h0, 32'h384, 32'h384, 32'h1, 32'h00000330 + 32'(k));
    end
    $display("test 4 done");
    stamp <= 32'h00000444;
    run_secs(3, 16'h0002);
    pulse(4);
    chk(cur_count_out, 32'h0);
    read_hist(4'h0, 32'h6, 32'h3, 32'h1, 32'h00000444);
    read_hist(4'h1, 32'h384, 32'h384, 32'h1, 32'h00000335);
    $display("test 5 done");
    run_secs(1030, 16'h0001);
    chk(cur_seconds_out, 32'h3ff);
    pulse(2);
    chk(daily_running_count_out, 32'h0);
    pulse(1);
    chk(cur_seconds_out, 32'h0);
    $display("test 6 done");
    stop_test();
  end
endmodule : tb_perf_interval_regs
